// >>> hw/file_auth_pkg.sv
// Shared constants and types of the file lifecycle and authentication block.
// Assumes a single AHB-Lite master and word-aligned 32-bit register accesses.
package file_auth_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ARG = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CURRENT = 8'h0c;
    localparam logic [7:0] OFF_TBL_IDX = 8'h10;
    localparam logic [7:0] OFF_TBL_DATA = 8'h14;
    localparam logic [7:0] OFF_RESP_LEN = 8'h18;
    localparam logic [7:0] OFF_COUNTS = 8'h1c;
    localparam logic [7:0] OFF_ACCESS = 8'h20;

    // Status words
    localparam logic [15:0] SW_RESET = 16'h0000;
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_IN_MORE = 16'h63f1;
    localparam logic [15:0] SW_IN_DONE = 16'h62f3;
    localparam logic [7:0] SW_OUT_MORE_HI = 8'h61;
    localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
    localparam logic [15:0] SW_BAD_DATA = 16'h6a80;
    localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
    localparam logic [15:0] SW_AC_FAIL = 16'h6982;
    localparam logic [15:0] SW_NO_EF = 16'h6986;
    localparam logic [15:0] SW_INS_NONE = 16'h6d00;

    // Selection control codes
    localparam logic [7:0] P1_BY_FID = 8'h00;
    localparam logic [7:0] P1_PATH_MF = 8'h08;
    localparam logic [7:0] P1_PATH_DF = 8'h09;
    localparam logic [7:0] P1_NONE = 8'h00;
    localparam logic [7:0] P2_NONE = 8'h00;

    // Chaining block types in the top three bits of P1
    localparam logic [2:0] BLK_FIRST_IN = 3'b100;
    localparam logic [2:0] BLK_NEXT_IN = 3'b000;
    localparam logic [2:0] BLK_RETX_IN = 3'b010;
    localparam logic [2:0] BLK_FIRST_OUT = 3'b101;
    localparam logic [2:0] BLK_NEXT_OUT = 3'b001;
    localparam logic [2:0] BLK_RETX_OUT = 3'b011;

    localparam logic [7:0] TAG_TLV = 8'h73;
    localparam logic [7:0] TAG_PLAIN = 8'h53;
    localparam logic [15:0] MAX_SEG = 16'h00ff;
    localparam logic [15:0] ROOT_FID_DEF = 16'h0001;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    typedef enum logic [1:0] {OP_DEACT, OP_ACT, OP_AUTH_EVEN, OP_AUTH_ODD} op_t;
    typedef enum logic [1:0] {CH_IDLE, CH_IN, CH_IN_DONE, CH_OUT} chain_t;
    typedef enum logic [1:0] {F_IDLE, F_FETCH, F_EVAL} fstate_t;
    typedef enum logic [2:0] {SEL_FID, SEL_MF, SEL_DF, SEL_CUR, SEL_BAD} sel_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic last_seg;
        logic data_empty;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [5:0] pad;
        op_t op;
    } cmd_t;

    typedef struct packed {
        logic [7:0] tag;
        logic [7:0] len;
        logic [15:0] fid;
    } arg_t;

    typedef struct packed {
        logic [15:0] fid;
        logic [15:0] parent;
        logic present;
        logic active;
        logic keep_rw;
        logic deact_ok;
        logic act_ok;
    } file_entry_t;

endpackage

// >>> hw/file_table.sv
// Small table of elementary file descriptors with a registered read port.
// Assumes one writer per cycle; unwritten entries read as all zero.
`timescale 1ns/10ps
module file_table
    import file_auth_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int IW = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write port
    input wire logic we,
    input wire logic [IW-1:0] waddr,
    input wire file_entry_t wdata,
    // Read port
    input wire logic [IW-1:0] raddr,
    output file_entry_t rdata_q
);
    file_entry_t mem [DEPTH];
    logic [DEPTH-1:0] valid_q;

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Valid bits keep a fresh table from returning undefined descriptors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_q <= '0;
            rdata_q <= '0;
        end else begin
            if (we) begin
                valid_q[waddr] <= 1'b1;
            end
            rdata_q <= valid_q[raddr] ? mem[raddr] : '0;
        end
    end
endmodule // file_table

// >>> hw/file_auth_core.sv
// AHB-Lite register slave running file lifecycle and authentication commands.
// Assumes a terminal-side transport that writes commands and reads status words.
// Function
// RL1: deactivate clears lifecycle active flag, reversible
// RL2: deactivate only when its access condition holds
// RL3: success makes addressed file current
// RL4: failure keeps current file pointers
// RL5: deactivated file refuses all but select/activate
// RL6: status bit b7 keeps read/update allowed
// RL7: P1 selects by identifier, master path, dedicated path
// RL8: empty data with zero P1/P2 uses current file
// RL9: activate restores active flag under its condition
// RL10: terminal selects application before authenticating
// RL11: even code only for short plain challenges
// RL12: odd data wrapped with tag 73 or 53
// RL13: chained blocks at most 255 bytes, concatenated
// RL14: terminal marks first and next blocks
// RL15: incomplete input answers 63 F1
// RL16: last input segment answers 62 F3
// RL17: first response request starts computation, segments
// RL18: final response segment answers 90 00
// RL19: retransmit repeats previous input or response block
// RL20: even authenticate needs P1 zero
// RL21: odd authenticate support is optional
// RL22: P1 top bits encode block type
// RL23: P2 bits b7 b6 must be zero
// RL24: reserved codes rejected, state kept
// RL25: pending response segments answer 61 xx
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module file_auth_core
    import file_auth_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter bit ODD_AUTH_EN = 1'b1,
    parameter logic [15:0] ROOT_FID = ROOT_FID_DEF
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_q,
    output logic hreadyout_q,
    output logic hresp_q,
    // Authentication engine
    output logic auth_start_q
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
        $error("file_auth_core: DEPTH must lie between 2 and 256");
    end

    function automatic sel_t sel_decode(input logic [7:0] p1, input logic empty);
        sel_t s;
        s = SEL_BAD;
        if (p1 == P1_BY_FID) begin
            s = empty ? SEL_CUR : SEL_FID;
        end else if (p1 == P1_PATH_MF && !empty) begin
            s = SEL_MF;
        end else if (p1 == P1_PATH_DF && !empty) begin
            s = SEL_DF;
        end
        return s;
    endfunction

    // Returns {other, update, read, select_activate}
    function automatic logic [3:0] access_bits(input logic active, input logic keep);
        return {active, active | keep, active | keep, 1'b1};
    endfunction

    logic wr_pend_q;
    logic [7:0] wa_q;
    logic [31:0] rd_mux;
    logic cmd_wr;
    cmd_t cmd_w;
    arg_t arg_q;
    logic [15:0] sw_q;
    logic [15:0] cur_df_q;
    logic [IW-1:0] cur_ef_q;
    logic cur_valid_q;
    logic cur_active_q;
    logic cur_keep_q;
    logic [12:0] tbl_idx_q;
    logic [15:0] resp_len_q;
    logic [15:0] in_count_q;
    logic [15:0] remain_q;
    logic [15:0] prev_seg_q;
    logic [7:0] prev_lc_q;
    logic prev_last_q;
    logic last_in_q;
    logic last_out_q;
    chain_t chain_q;
    fstate_t fstate_q;
    op_t fop_q;
    sel_t fsel_q;
    logic fsingle_q;
    logic [IW-1:0] idx_q;
    file_entry_t rdata;
    file_entry_t fwdata;
    logic hit;
    logic ac_ok;
    logic fsm_we;
    logic tbl_we;
    logic mem_we;
    logic [IW-1:0] mem_waddr;
    file_entry_t mem_wdata;
    logic start_file;
    logic start_auth;
    logic auth_ok;
    logic [15:0] auth_sw;
    logic [2:0] blk;
    logic [15:0] want;
    logic [15:0] base;
    logic [15:0] seg;
    logic [15:0] rem_after;

    assign cmd_w = cmd_t'(hwdata);
    assign cmd_wr = wr_pend_q && wa_q == OFF_CMD;
    assign start_file = cmd_wr && fstate_q == F_IDLE && !cmd_w.op[1];
    assign start_auth = cmd_wr && fstate_q == F_IDLE && cmd_w.op[1];
    assign tbl_we = wr_pend_q && wa_q == OFF_TBL_DATA && fstate_q == F_IDLE;

    always_comb begin
        rd_mux = RDATA_NONE;
        case ({haddr[7:2], 2'b00})
            OFF_ARG: rd_mux = arg_q;
            OFF_STATUS: rd_mux = {13'h0000, chain_q, fstate_q != F_IDLE, sw_q};
            OFF_CURRENT: rd_mux = {cur_df_q, 7'h00, cur_valid_q, 8'(cur_ef_q)};
            OFF_TBL_IDX: rd_mux = {19'h00000, tbl_idx_q};
            OFF_RESP_LEN: rd_mux = {16'h0000, resp_len_q};
            OFF_COUNTS: rd_mux = {prev_seg_q, in_count_q};
            OFF_ACCESS: rd_mux = {28'h0000000, access_bits(cur_active_q, cur_keep_q)}; // see RL5 RL6
            default: rd_mux = RDATA_NONE;
        endcase
    end

    // Zero-wait slave: read data is latched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wa_q <= '0;
            hrdata_q <= RDATA_NONE;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            wr_pend_q <= hsel && htrans[1] && hready && hwrite;
            wa_q <= {haddr[7:2], 2'b00};
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arg_q <= '0;
            tbl_idx_q <= '0;
            resp_len_q <= '0;
            cur_df_q <= ROOT_FID;
        end else if (wr_pend_q) begin
            case (wa_q)
                OFF_ARG: arg_q <= arg_t'(hwdata);
                OFF_TBL_IDX: tbl_idx_q <= hwdata[12:0];
                OFF_RESP_LEN: resp_len_q <= hwdata[15:0];
                OFF_CURRENT: cur_df_q <= hwdata[31:16];
                default: ;
            endcase
        end
    end

    // File scan evaluation
    always_comb begin
        hit = 1'b0;
        if (rdata.present) begin
            if (fsingle_q) begin
                hit = 1'b1;
            end else if (rdata.fid == arg_q.fid) begin
                hit = (fsel_q == SEL_MF) ? rdata.parent == ROOT_FID : rdata.parent == cur_df_q; // see RL7
            end
        end
        ac_ok = (fop_q == OP_DEACT) ? rdata.deact_ok : rdata.act_ok; // see RL2 RL9
        fsm_we = fstate_q == F_EVAL && hit && ac_ok;
        fwdata = rdata;
        fwdata.active = fop_q == OP_ACT; // see RL1 RL9
    end

    assign mem_we = fsm_we || tbl_we;
    assign mem_waddr = fsm_we ? idx_q : tbl_idx_q[IW-1:0];
    assign mem_wdata = fsm_we ? fwdata : {hwdata, tbl_idx_q[12:8]};

    file_table #(.DEPTH(DEPTH), .IW(IW)) u_table (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(idx_q),
        .rdata_q(rdata)
    );

    // File command sequencer; one entry every two cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fstate_q <= F_IDLE;
            fop_q <= OP_DEACT;
            fsel_q <= SEL_FID;
            fsingle_q <= 1'b0;
            idx_q <= '0;
        end else begin
            case (fstate_q)
                F_IDLE: begin
                    if (start_file && cmd_w.p2 == P2_NONE) begin
                        fop_q <= cmd_w.op;
                        fsel_q <= sel_decode(cmd_w.p1, cmd_w.data_empty);
                        fsingle_q <= sel_decode(cmd_w.p1, cmd_w.data_empty) == SEL_CUR;
                        idx_q <= cur_ef_q; // see RL8
                        if (sel_decode(cmd_w.p1, cmd_w.data_empty) != SEL_CUR) begin
                            idx_q <= '0;
                        end
                        if (sel_decode(cmd_w.p1, cmd_w.data_empty) != SEL_BAD &&
                            (sel_decode(cmd_w.p1, cmd_w.data_empty) != SEL_CUR || cur_valid_q)) begin
                            fstate_q <= F_FETCH;
                        end
                    end
                end
                F_FETCH: fstate_q <= F_EVAL;
                F_EVAL: begin
                    if (hit || fsingle_q || idx_q == IW'(DEPTH - 1)) begin
                        fstate_q <= F_IDLE;
                    end else begin
                        idx_q <= idx_q + 1'b1;
                        fstate_q <= F_FETCH;
                    end
                end
                default: fstate_q <= F_IDLE;
            endcase
        end
    end

    // Current file pointer and cached lifecycle flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ef_q <= '0;
            cur_valid_q <= 1'b0;
            cur_active_q <= 1'b0;
            cur_keep_q <= 1'b0;
        end else if (fsm_we) begin // see RL4
            cur_ef_q <= idx_q; // see RL3
            cur_valid_q <= 1'b1;
            cur_active_q <= fwdata.active;
            cur_keep_q <= fwdata.keep_rw;
        end else if (tbl_we && cur_valid_q && tbl_idx_q[IW-1:0] == cur_ef_q) begin
            cur_active_q <= tbl_idx_q[11];
            cur_keep_q <= tbl_idx_q[10];
        end
    end

    // Authentication decode; blocks are measured in bytes
    always_comb begin
        blk = cmd_w.p1[7:5];
        want = (arg_q.len == 8'h00) ? MAX_SEG : {8'h00, arg_q.len}; // see RL13
        base = (blk == BLK_RETX_OUT) ? remain_q + prev_seg_q : remain_q; // see RL19
        if (blk == BLK_FIRST_OUT) begin
            base = resp_len_q;
        end
        seg = (base < want) ? base : want;
        rem_after = base - seg;
        auth_ok = 1'b0;
        auth_sw = SW_BAD_P1P2;
        if (cmd_w.p2[6:5] != 2'b00) begin
            auth_sw = SW_BAD_P1P2; // see RL23
        end else if (cmd_w.op == OP_AUTH_EVEN) begin
            auth_ok = cmd_w.p1 == P1_NONE; // see RL20
            auth_sw = auth_ok ? SW_OK : SW_BAD_P1P2;
        end else if (!ODD_AUTH_EN) begin
            auth_sw = SW_INS_NONE; // see RL21
        end else begin
            case (blk) // see RL22
                BLK_FIRST_IN: auth_ok = arg_q.tag == TAG_TLV || arg_q.tag == TAG_PLAIN;
                BLK_NEXT_IN: auth_ok = chain_q == CH_IN;
                BLK_RETX_IN: auth_ok = last_in_q;
                BLK_FIRST_OUT: auth_ok = chain_q == CH_IN_DONE;
                BLK_NEXT_OUT: auth_ok = chain_q == CH_OUT;
                BLK_RETX_OUT: auth_ok = last_out_q;
                default: auth_ok = 1'b0; // see RL24
            endcase
            if (!blk[0]) begin
                auth_sw = cmd_w.last_seg ? SW_IN_DONE : SW_IN_MORE; // see RL15 RL16
            end else if (rem_after == 16'h0000) begin
                auth_sw = SW_OK; // see RL18
            end else begin
                auth_sw = {SW_OUT_MORE_HI, (rem_after > MAX_SEG) ? 8'hff : rem_after[7:0]}; // see RL25
            end
            if (!auth_ok) begin
                auth_sw = (blk == BLK_FIRST_IN) ? SW_BAD_DATA : SW_BAD_P1P2; // see RL12 RL24
            end
        end
    end

    // Chaining state; a refused block leaves all of it untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_q <= CH_IDLE;
            in_count_q <= '0;
            remain_q <= '0;
            prev_seg_q <= '0;
            prev_lc_q <= '0;
            prev_last_q <= 1'b0;
            last_in_q <= 1'b0;
            last_out_q <= 1'b0;
            auth_start_q <= 1'b0;
        end else begin
            auth_start_q <= start_auth && auth_ok &&
                (cmd_w.op == OP_AUTH_EVEN || blk == BLK_FIRST_OUT); // see RL17
            if (start_auth && auth_ok && cmd_w.op == OP_AUTH_ODD) begin
                last_in_q <= !blk[0];
                last_out_q <= blk[0];
                if (!blk[0]) begin
                    prev_lc_q <= arg_q.len;
                    prev_last_q <= cmd_w.last_seg;
                    chain_q <= cmd_w.last_seg ? CH_IN_DONE : CH_IN;
                    case (blk)
                        BLK_FIRST_IN: in_count_q <= {8'h00, arg_q.len};
                        BLK_RETX_IN: in_count_q <= in_count_q - prev_lc_q + arg_q.len; // see RL19
                        default: in_count_q <= in_count_q + arg_q.len; // see RL13
                    endcase
                end else begin
                    remain_q <= rem_after;
                    prev_seg_q <= seg;
                    chain_q <= (rem_after == 16'h0000) ? CH_IDLE : CH_OUT;
                end
            end
        end
    end

    // Status word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_q <= SW_RESET;
        end else if (start_auth) begin
            sw_q <= auth_sw;
        end else if (start_file) begin
            if (cmd_w.p2 != P2_NONE || sel_decode(cmd_w.p1, cmd_w.data_empty) == SEL_BAD) begin
                sw_q <= SW_BAD_P1P2; // see RL24
            end else if (sel_decode(cmd_w.p1, cmd_w.data_empty) == SEL_CUR && !cur_valid_q) begin
                sw_q <= SW_NO_EF;
            end
        end else if (fstate_q == F_EVAL) begin
            if (hit) begin
                sw_q <= ac_ok ? SW_OK : SW_AC_FAIL;
            end else if (fsingle_q || idx_q == IW'(DEPTH - 1)) begin
                sw_q <= SW_NOT_FOUND;
            end
        end
    end

    chk_fail_keeps_ef: assert property ( // see RL4
        @(posedge hclk) disable iff (!hresetn)
        fstate_q == F_EVAL && !fsm_we |=> $stable(cur_ef_q) && $stable(cur_valid_q))
        else $error("current file moved after a failed file command");

    chk_ok_sets_ef: assert property ( // see RL3
        @(posedge hclk) disable iff (!hresetn)
        fsm_we |=> cur_ef_q == $past(idx_q) && cur_valid_q && sw_q == SW_OK)
        else $error("successful file command did not make its file current");

    chk_flag_write: assert property ( // see RL1
        @(posedge hclk) disable iff (!hresetn)
        fsm_we |-> ##2 rdata.active == ($past(fop_q, 2) == OP_ACT))
        else $error("lifecycle flag written wrongly");

    chk_ac_gate: assert property ( // see RL2
        @(posedge hclk) disable iff (!hresetn)
        fstate_q == F_EVAL && hit && !ac_ok |-> !fsm_we ##1 sw_q == SW_AC_FAIL)
        else $error("file command ran without its access condition");

    chk_in_more: assert property ( // see RL15
        @(posedge hclk) disable iff (!hresetn)
        start_auth && auth_ok && cmd_w.op == OP_AUTH_ODD && !blk[0] && !cmd_w.last_seg
        |=> sw_q == SW_IN_MORE && chain_q == CH_IN)
        else $error("incomplete input not answered with 63 F1");

    chk_in_last: assert property ( // see RL16
        @(posedge hclk) disable iff (!hresetn)
        start_auth && auth_ok && cmd_w.op == OP_AUTH_ODD && !blk[0] && cmd_w.last_seg
        |=> sw_q == SW_IN_DONE && chain_q == CH_IN_DONE)
        else $error("last input segment not answered with 62 F3");

    chk_out_final: assert property ( // see RL18
        @(posedge hclk) disable iff (!hresetn)
        start_auth && auth_ok && cmd_w.op == OP_AUTH_ODD && blk[0] && rem_after == 16'h0000
        |=> sw_q == SW_OK && remain_q == 16'h0000)
        else $error("final response segment not answered with 90 00");

    chk_reserved_keep: assert property ( // see RL24
        @(posedge hclk) disable iff (!hresetn)
        start_auth && !auth_ok |=> $stable(chain_q) && $stable(in_count_q) && $stable(remain_q))
        else $error("refused authenticate changed the chaining state");

    chk_access_b7: assert property ( // see RL5
        @(posedge hclk) disable iff (!hresetn)
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFF_ACCESS && !cur_active_q
        |=> hrdata_q[3] == 1'b0 && hrdata_q[1] == $past(cur_keep_q))
        else $error("deactivated file access bits wrong");
endmodule // file_auth_core

// >>> tb/terminal_model.sv
// Terminal side model: an AHB-Lite master issuing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module terminal_model (
    // Clock
    input wire logic hclk,
    // Master outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Slave answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // Write data is inverted once released so a stale value never looks valid
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule // terminal_model

// >>> tb/test_file_state_and_auth_chaining.sv
// Testbench for the file lifecycle and authentication block.
// Assumes the terminal model drives the bus; commands go through registers.
`timescale 1ns/10ps
module test_file_state_and_auth_chaining;
    import file_auth_pkg::*;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic hreadyout;
    logic hresp;
    logic auth_start;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] hrdata2;
    logic [31:0] rd;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] starts = 32'h0;

    terminal_model model_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    file_auth_core #(.DEPTH(16)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata_q(hrdata), .hreadyout_q(hreadyout), .hresp_q(hresp),
        .auth_start_q(auth_start));

    // Same block built without odd authenticate; it shares the bus and only its reads are watched
    file_auth_core #(.DEPTH(16), .ODD_AUTH_EN(1'b0)) even_only_u (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata_q(hrdata2),
        .hreadyout_q(), .hresp_q(), .auth_start_q());

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cycles++;
        if (auth_start === 1'b1) starts <= starts + 32'h1;
        if (cycles == 20000) begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        model_u.xfer(a, 1'b1, d, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        model_u.xfer(a, 1'b0, 32'h0, rd);
        chk(rd & m, e, "read");
        chk({30'h0, hreadyout, hresp}, 32'h2, "ready and response");
    endtask

    // Issue a command, wait out any file scan, then check the status word
    task automatic cmd(input logic [1:0] op, input logic [7:0] p1, input logic [7:0] p2,
                       input logic [1:0] fl, input logic [15:0] sw);
        int i;
        wr(OFF_CMD, {6'h00, fl, p2, p1, 6'h00, op});
        for (i = 0; i < 100; i++) begin
            model_u.xfer(OFF_STATUS, 1'b0, 32'h0, rd);
            if (rd[16] === 1'b0) break;
        end
        chk({15'h0, rd[16], rd[15:0]}, {16'h0, sw}, "status");
    endtask

    initial begin
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OFF_STATUS, 32'hffff_ffff, 32'h0);
        rd_chk(OFF_CURRENT, 32'hffff_01ff, {ROOT_FID_DEF, 16'h0000});
        wr(8'h3c, 32'h1234_5678);
        rd_chk(8'h3c, 32'hffff_ffff, 32'h0);
        // Entry 0 lacks both permissions; entry 1 keeps read/update
        wr(OFF_TBL_IDX, 32'h0000_1800);
        wr(OFF_TBL_DATA, 32'h2f01_0001);
        wr(OFF_TBL_IDX, 32'h0000_1f01);
        wr(OFF_TBL_DATA, 32'h2f02_0001);
        wr(OFF_ARG, 32'h0000_2f01);
        cmd(OP_DEACT, P1_BY_FID, P2_NONE, 2'b00, SW_AC_FAIL);
        rd_chk(OFF_CURRENT, 32'h0000_0100, 32'h0);
        cmd(OP_ACT, P1_BY_FID, P2_NONE, 2'b00, SW_AC_FAIL);
        cmd(OP_DEACT, P1_NONE, P2_NONE, 2'b01, SW_NO_EF);
        wr(OFF_ARG, 32'h0002_2f02);
        cmd(OP_DEACT, P1_PATH_MF, P2_NONE, 2'b00, SW_OK);
        rd_chk(OFF_CURRENT, 32'h0000_01ff, 32'h0000_0101);
        rd_chk(OFF_ACCESS, 32'hf, 32'h7);
        cmd(OP_ACT, P1_NONE, P2_NONE, 2'b01, SW_OK);
        rd_chk(OFF_ACCESS, 32'hf, 32'hf);
        cmd(OP_DEACT, 8'h01, P2_NONE, 2'b00, SW_BAD_P1P2);
        cmd(OP_DEACT, P1_PATH_DF, 8'h01, 2'b00, SW_BAD_P1P2);
        rd_chk(OFF_ACCESS, 32'hf, 32'hf);
        wr(OFF_ARG, 32'h0000_3333);
        cmd(OP_DEACT, P1_PATH_DF, P2_NONE, 2'b00, SW_NOT_FOUND);
        rd_chk(OFF_CURRENT, 32'h0000_01ff, 32'h0000_0101);
        $display("file test done");
        cmd(OP_AUTH_EVEN, 8'h00, P2_NONE, 2'b00, SW_OK);
        cmd(OP_AUTH_EVEN, 8'h01, P2_NONE, 2'b00, SW_BAD_P1P2);
        chk(starts, 32'h1, "starts");
        wr(OFF_ARG, 32'h55ff_0000);
        cmd(OP_AUTH_ODD, 8'h80, 8'h81, 2'b00, SW_BAD_DATA);
        chk(hrdata2 & 32'h0000_ffff, {16'h0, SW_INS_NONE}, "odd off");
        wr(OFF_ARG, 32'h73ff_0000);
        cmd(OP_AUTH_ODD, 8'h80, 8'h40, 2'b00, SW_BAD_P1P2);
        cmd(OP_AUTH_ODD, 8'h80, 8'h81, 2'b00, SW_IN_MORE);
        cmd(OP_AUTH_ODD, 8'h40, 8'h81, 2'b00, SW_IN_MORE);
        rd_chk(OFF_COUNTS, 32'h0000_ffff, 32'h0000_00ff);
        wr(OFF_ARG, 32'h0010_0000);
        cmd(OP_AUTH_ODD, 8'h00, 8'h81, 2'b10, SW_IN_DONE);
        rd_chk(OFF_COUNTS, 32'h0000_ffff, 32'h0000_010f);
        rd_chk(OFF_STATUS, 32'h0006_0000, 32'h0004_0000);
        wr(OFF_RESP_LEN, 32'h0000_012c);
        wr(OFF_ARG, 32'h0000_0000);
        cmd(OP_AUTH_ODD, 8'ha0, 8'h81, 2'b00, {SW_OUT_MORE_HI, 8'h2d});
        chk(starts, 32'h2, "starts");
        cmd(OP_AUTH_ODD, 8'h60, 8'h81, 2'b00, {SW_OUT_MORE_HI, 8'h2d});
        cmd(OP_AUTH_ODD, 8'h20, 8'h81, 2'b00, SW_OK);
        rd_chk(OFF_COUNTS, 32'hffff_0000, 32'h002d_0000);
        cmd(OP_AUTH_ODD, 8'h20, 8'h81, 2'b00, SW_BAD_P1P2);
        $display("auth test done");
        stop_test();
    end
endmodule // test_file_state_and_auth_chaining
